// *** hw/hpsc_pkg.sv ***
`default_nettype none
package hpsc_pkg;

  // ==========================================================
  // Reset values and cycle counts
  // ==========================================================
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned AUX_GOOD_US     = 1;
  localparam int unsigned AUX_GOOD_CYC    = AUX_GOOD_US * CLK_MHZ;
  localparam int unsigned RAMP_US         = 2;
  localparam int unsigned RAMP_CYC        = RAMP_US * CLK_MHZ;
  localparam int unsigned DISCH_US        = 1;
  localparam int unsigned DISCH_CYC       = DISCH_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 12;
  localparam logic [2:0]  CAP_RST         = 3'h0;

  // Capability sense levels from the five-level converter
  typedef enum logic [2:0] {
    HPSC_CAP_CONV   = 3'h0,
    HPSC_CAP_M66    = 3'h1,
    HPSC_CAP_M133   = 3'h2,
    HPSC_CAP_M266   = 3'h3,
    HPSC_CAP_M533   = 3'h4
  } hpsc_cap_t;

  typedef struct packed {
    logic power_led_request;
    logic attention_led_request;
    logic io_voltage_select;
    logic aux_power_enable;
    logic main_power_enable;
    logic system_power_good;
    logic slot_wake_event;
  } hpsc_ctl_t;

  typedef struct packed {
    logic main_overcurrent;
    logic aux_overcurrent;
    logic main_below_range;
    logic outputs_discharged;
  } hpsc_sense_t;

  typedef enum logic [1:0] {
    HPSC_ST_OFF,
    HPSC_ST_RAMP,
    HPSC_ST_ON,
    HPSC_ST_FAULT
  } hpsc_state_t;

  // Saturating count-down shared by the timers
  function automatic logic [CNT_W-1:0] hpsc_dec(input logic [CNT_W-1:0] c);
    hpsc_dec = (c == '0) ? c : c - 12'h001;
  endfunction

endpackage
`default_nettype wire

// *** hw/hpsc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
    if (!rst_b_i) begin
      next_meta = '0;
      next_q    = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    meta <= next_meta;
    q_o  <= next_q;
  end
endmodule
`default_nettype wire

// *** hw/hpsc_slot.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpsc_slot
  import hpsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire hpsc_ctl_t   ctl_i,
  input  wire hpsc_sense_t sense_i,
  input  wire logic [2:0]  card_capability_sense_i,
  output logic             power_led_drive_n_o,
  output logic             attention_led_drive_n_o,
  output logic             io_sel_3v3_o,
  output logic             io_sel_1v5_o,
  output logic             aux_power_on_o,
  output logic             main_power_on_o,
  output logic             pos12_output_o,
  output logic             neg12_output_o,
  output logic             rail_discharge_o,
  output logic             power_discharged_n_o,
  output logic             output_undervoltage_n_o,
  output logic             aux_fault_n_o,
  output logic             main_fault_n_o,
  output logic             capability_bit1_o,
  output logic             capability_bit2_o,
  output logic             capability_bit3_o,
  output logic             system_wake_event_out_o
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  hpsc_ctl_t   ctl;
  hpsc_sense_t sense;
  logic [2:0]  cap_raw;

  hpsc_sync #(.W($bits(hpsc_ctl_t))) u_sync_ctl (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (ctl_i),
    .q_o     (ctl)
  );

  hpsc_sync #(.W($bits(hpsc_sense_t) + 3)) u_sync_sense (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({sense_i, card_capability_sense_i}),
    .q_o     ({sense, cap_raw})
  );

  // ==========================================================
  // Main power sequencer
  // ==========================================================
  hpsc_state_t      state;
  hpsc_state_t      next_state;
  logic [CNT_W-1:0] ramp_cnt;
  logic [CNT_W-1:0] next_ramp_cnt;
  logic             main_fault;
  logic             next_main_fault;
  logic             aux_fault;
  logic             next_aux_fault;
  logic             main_req;

  // Power good qualifies main enable; aux fault also kills main
  assign main_req = ctl.main_power_enable && ctl.system_power_good
                    && !aux_fault;

  always_comb begin
    next_state      = state;
    next_ramp_cnt   = hpsc_dec(ramp_cnt);
    next_main_fault = main_fault;
    next_aux_fault  = aux_fault;
    if (sense.aux_overcurrent && ctl.aux_power_enable) begin
      next_aux_fault = 1'b1;
    end else if (!ctl.aux_power_enable) begin
      next_aux_fault = 1'b0;
    end
    unique case (state)
      HPSC_ST_OFF: begin
        if (main_req) begin
          next_state    = HPSC_ST_RAMP;
          next_ramp_cnt = CNT_W'(RAMP_CYC);
        end
      end
      HPSC_ST_RAMP: begin
        if (!main_req) begin
          next_state = HPSC_ST_OFF;
        end else if (sense.main_overcurrent) begin
          next_state      = HPSC_ST_FAULT;
          next_main_fault = 1'b1;
        end else if (ramp_cnt == '0) begin
          next_state = HPSC_ST_ON;
        end
      end
      HPSC_ST_ON: begin
        if (!main_req) begin
          next_state = HPSC_ST_OFF;
        end else if (sense.main_overcurrent) begin
          next_state      = HPSC_ST_FAULT;
          next_main_fault = 1'b1;
        end
      end
      HPSC_ST_FAULT: begin
        // Latched until software drops the enable
        if (!ctl.main_power_enable) begin
          next_state      = HPSC_ST_OFF;
          next_main_fault = 1'b0;
        end
      end
    endcase
    if (!rst_b_i) begin
      next_state      = HPSC_ST_OFF;
      next_ramp_cnt   = '0;
      next_main_fault = 1'b0;
      next_aux_fault  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    state      <= next_state;
    ramp_cnt   <= next_ramp_cnt;
    main_fault <= next_main_fault;
    aux_fault  <= next_aux_fault;
  end

  // ==========================================================
  // Aux good timer and wake event switch
  // ==========================================================
  logic [CNT_W-1:0] aux_cnt;
  logic [CNT_W-1:0] next_aux_cnt;
  logic             aux_good;
  logic             next_aux_good;

  always_comb begin
    next_aux_cnt  = hpsc_dec(aux_cnt);
    next_aux_good = aux_good;
    if (!ctl.aux_power_enable || aux_fault
        || sense.aux_overcurrent) begin
      next_aux_cnt  = CNT_W'(AUX_GOOD_CYC);
      next_aux_good = 1'b0;
    end else if (aux_cnt == '0) begin
      next_aux_good = 1'b1;
    end
    if (!rst_b_i) begin
      next_aux_cnt  = CNT_W'(AUX_GOOD_CYC);
      next_aux_good = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    aux_cnt  <= next_aux_cnt;
    aux_good <= next_aux_good;
  end

  // ==========================================================
  // Discharge timer
  // ==========================================================
  logic [CNT_W-1:0] dis_cnt;
  logic [CNT_W-1:0] next_dis_cnt;
  logic             rails_off;

  // Besides the outputs_discharged sense of the rails, wait a fixed bleed time as well
  assign rails_off = (state == HPSC_ST_OFF || state == HPSC_ST_FAULT)
                     && !ctl.aux_power_enable;

  always_comb begin
    next_dis_cnt = hpsc_dec(dis_cnt);
    if (!rails_off || !rst_b_i) begin
      next_dis_cnt = CNT_W'(DISCH_CYC);
    end
  end

  always_ff @(posedge clk_i) begin
    dis_cnt <= next_dis_cnt;
  end

  // ==========================================================
  // Capability decode
  // ==========================================================
  hpsc_cap_t  cap;
  hpsc_cap_t  next_cap;
  logic [2:0] cap_prev;
  logic [2:0] next_cap_prev;

  // Code bits are synchronised one by one; taking a code only after two
  // equal samples keeps a skew between bits off the output pins
  always_comb begin
    next_cap      = cap;
    next_cap_prev = cap_raw;
    if (cap_raw == cap_prev) begin
      unique case (cap_raw)
        3'h0:    next_cap = HPSC_CAP_CONV;
        3'h1:    next_cap = HPSC_CAP_M66;
        3'h2:    next_cap = HPSC_CAP_M133;
        3'h3:    next_cap = HPSC_CAP_M266;
        default: next_cap = HPSC_CAP_M533; // Out of range saturates
      endcase
    end
    if (!rst_b_i) begin
      next_cap      = hpsc_cap_t'(CAP_RST);
      next_cap_prev = 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    cap      <= next_cap;
    cap_prev <= next_cap_prev;
  end

  // ==========================================================
  // Output registers
  // ==========================================================
  logic next_on;
  logic next_rail;

  always_comb begin
    next_on   = (state == HPSC_ST_RAMP || state == HPSC_ST_ON)
                && main_req && !main_fault;
    next_rail = next_on && !sense.main_overcurrent;
    if (!rst_b_i) begin
      next_on   = 1'b0;
      next_rail = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    power_led_drive_n_o     <= !(rst_b_i && ctl.power_led_request);
    attention_led_drive_n_o <= !(rst_b_i
                                 && ctl.attention_led_request);
    io_sel_3v3_o            <= next_on && ctl.io_voltage_select;
    io_sel_1v5_o            <= next_on && !ctl.io_voltage_select;
    aux_power_on_o          <= rst_b_i && ctl.aux_power_enable
                               && !aux_fault;
    main_power_on_o         <= next_on;
    pos12_output_o          <= next_rail;
    neg12_output_o          <= next_rail; // same ramp control
    rail_discharge_o        <= !next_rail;
    power_discharged_n_o    <= !(rails_off && dis_cnt == '0
                                 && sense.outputs_discharged);
    output_undervoltage_n_o <= !(!rst_b_i || !ctl.main_power_enable
                                 || state != HPSC_ST_ON
                                 || sense.main_below_range);
    aux_fault_n_o           <= !(rst_b_i && next_aux_fault);
    main_fault_n_o          <= !(rst_b_i && next_main_fault);
    capability_bit1_o       <= next_cap[0];
    capability_bit2_o       <= next_cap[1];
    capability_bit3_o       <= next_cap[2];
    system_wake_event_out_o <= next_aux_good
                               && ctl.slot_wake_event;
  end

endmodule
`default_nettype wire

// *** verif/hpsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpsc_host_model
  import hpsc_pkg::*;
(
  input  wire logic      sys_ok_i,
  input  wire hpsc_ctl_t cmd_i,
  output hpsc_ctl_t      ctl_o
);
  // ==========================================
  // Host side: plain levels, power good gated
  always_comb begin
    ctl_o = cmd_i;
    ctl_o.system_power_good = cmd_i.system_power_good & sys_ok_i;
  end
endmodule
`default_nettype wire

// *** verif/hpsc_slot_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module hpsc_slot_asserts
  import hpsc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire hpsc_ctl_t  ctl_i,
  input wire logic [2:0] card_capability_sense_i,
  input wire logic       power_led_drive_n_o,
  input wire logic       attention_led_drive_n_o,
  input wire logic       io_sel_3v3_o,
  input wire logic       io_sel_1v5_o,
  input wire logic       aux_power_on_o,
  input wire logic       main_power_on_o,
  input wire logic       pos12_output_o,
  input wire logic       neg12_output_o,
  input wire logic       rail_discharge_o,
  input wire logic       power_discharged_n_o,
  input wire logic       output_undervoltage_n_o,
  input wire logic       aux_fault_n_o,
  input wire logic       main_fault_n_o,
  input wire logic       capability_bit1_o,
  input wire logic       capability_bit2_o,
  input wire logic       capability_bit3_o,
  input wire logic       system_wake_event_out_o
);
  // ==========================================
  // Settled-level checks, 5 cycles cover sync
  logic [2:0] cap_exp;
  assign cap_exp = (card_capability_sense_i > 3'h4) ? 3'h4
                                                     : card_capability_sense_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_pled_follow: assert property ($stable(ctl_i.power_led_request)[*5]
    |-> power_led_drive_n_o == !ctl_i.power_led_request) else $error("pled");
  a_aled_follow: assert property (
    $stable(ctl_i.attention_led_request)[*5]
    |-> attention_led_drive_n_o == !ctl_i.attention_led_request)
    else $error("aled");
  a_cap_decode: assert property ($stable(card_capability_sense_i)[*5]
    |-> {capability_bit3_o, capability_bit2_o, capability_bit1_o} == cap_exp)
    else $error("cap");
  a_main_gate: assert property ((!ctl_i.main_power_enable)[*5]
    |-> !main_power_on_o) else $error("main on");
  a_rails_ground: assert property ((!ctl_i.main_power_enable)[*5]
    |-> !pos12_output_o && rail_discharge_o) else $error("rails");
  a_off_status: assert property ((!ctl_i.main_power_enable)[*5]
    |-> !output_undervoltage_n_o && main_fault_n_o) else $error("off st");
  a_fault_rails: assert property ((!main_fault_n_o)[*2]
    |-> !pos12_output_o && !neg12_output_o) else $error("fault rails");
  a_rail_track: assert property (pos12_output_o == neg12_output_o)
    else $error("track");
  a_aux_clear: assert property ((!ctl_i.aux_power_enable)[*5]
    |-> aux_fault_n_o && !aux_power_on_o) else $error("aux clr");
  a_wake_cut: assert property ((!ctl_i.aux_power_enable)[*5]
    |-> !system_wake_event_out_o) else $error("wake");
  a_dis_state: assert property (!power_discharged_n_o
    |-> !pos12_output_o && !main_power_on_o && !aux_power_on_o)
    else $error("disch");
  a_io_excl: assert property (!(io_sel_3v3_o && io_sel_1v5_o))
    else $error("io");
  c_main_on: cover property (main_power_on_o);
  c_fault: cover property (!main_fault_n_o);
  c_wake: cover property (system_wake_event_out_o);
  c_disch: cover property (!power_discharged_n_o);
endmodule
bind hpsc_slot hpsc_slot_asserts u_chk (.*);
`default_nettype wire

// *** verif/hot_plug_slot_power_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module hot_plug_slot_power_control_test;
  import hpsc_pkg::*;
  logic clk_i, rst_b_i, sys_ok, pl_n, al_n, v33, v15, aon, mon, p12, m12;
  logic dis, off_n, uv_n, af_n, mf_n, b1, b2, b3, wk;
  logic [2:0]  cap;
  hpsc_ctl_t   cmd, ctl;
  hpsc_sense_t sns;
  int          error_cnt, samples_checked, cyc;
  hpsc_host_model HOST (.sys_ok_i(sys_ok), .cmd_i(cmd), .ctl_o(ctl));
  hpsc_slot DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ctl_i(ctl),
    .sense_i(sns), .card_capability_sense_i(cap),
    .power_led_drive_n_o(pl_n), .attention_led_drive_n_o(al_n),
    .io_sel_3v3_o(v33), .io_sel_1v5_o(v15), .aux_power_on_o(aon),
    .main_power_on_o(mon), .pos12_output_o(p12), .neg12_output_o(m12),
    .rail_discharge_o(dis), .power_discharged_n_o(off_n),
    .output_undervoltage_n_o(uv_n), .aux_fault_n_o(af_n),
    .main_fault_n_o(mf_n), .capability_bit1_o(b1), .capability_bit2_o(b2),
    .capability_bit3_o(b3), .system_wake_event_out_o(wk));
  // ==========================================
  // Helpers
  function automatic logic [2:0] cap_exp(input logic [2:0] c);
    return (c > 3'h4) ? 3'h4 : c;
  endfunction
  task automatic chk(input string nm, input logic [2:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial cyc = 0;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_b_i = 0;
    sys_ok = 1;
    cmd = '0;
    sns = '0;
    cap = 3'h0;
    void'($urandom(32'hd5fa));
    wt(20);
    rst_b_i = 1;
    for (int i = 0; i < 40; i++) begin
      cmd = hpsc_ctl_t'(7'($urandom));
      cap = (i < 8) ? 3'(i) : 3'($urandom);
      wt(8);
      chk("pled_n", 3'(pl_n), 3'(!cmd.power_led_request));
      chk("aled_n", 3'(al_n), 3'(!cmd.attention_led_request));
      chk("cap", {b3, b2, b1}, cap_exp(cap));
      chk("aux_on", 3'(aon), 3'(cmd.aux_power_enable));
      if (!cmd.main_power_enable)
        chk("off_uv_rail", {uv_n, p12, mon}, 3'h0);
    end
    cmd = '0;
    wt(8);
    cmd.aux_power_enable = 1;
    cmd.system_power_good = 1;
    cmd.main_power_enable = 1;
    sys_ok = 0;
    wt(10);
    chk("main_refused", 3'(mon), 3'h0);
    sys_ok = 1;
    sns.main_below_range = 1;
    wt(6);
    chk("rails_on", {mon, p12, m12}, 3'h7);
    wt(RAMP_CYC + 10);
    chk("uv_low", 3'(uv_n), 3'h0);
    sns.main_below_range = 0;
    cmd.io_voltage_select = 1;
    wt(8);
    chk("uv_io33", {uv_n, v33, v15}, 3'h6);
    cmd.io_voltage_select = 0;
    wt(8);
    chk("io15", {1'b0, v33, v15}, 3'h1);
    sns.main_overcurrent = 1;
    wt(6);
    sns.main_overcurrent = 0;
    wt(6);
    chk("fault_latch", {mf_n, p12, dis}, 3'h1);
    cmd.main_power_enable = 0;
    wt(8);
    chk("fault_clr", {1'b0, mf_n, uv_n}, 3'h2);
    cmd.slot_wake_event = 1;
    wt(8);
    chk("wake_on", 3'(wk), 3'h1);
    sns.aux_overcurrent = 1;
    wt(6);
    chk("aux_fault", {1'b0, af_n, wk}, 3'h0);
    sns.aux_overcurrent = 0;
    cmd.aux_power_enable = 0;
    wt(8);
    chk("aux_clr", 3'(af_n), 3'h1);
    cmd.aux_power_enable = 1;
    wt(AUX_GOOD_CYC - 20);
    chk("wake_early", 3'(wk), 3'h0);
    wt(30);
    chk("wake_late", 3'(wk), 3'h1);
    cmd = '0;
    sns.outputs_discharged = 1;
    wt(DISCH_CYC + 20);
    chk("disch_n", 3'(off_n), 3'h0);
    sns.outputs_discharged = 0;
    wt(8);
    chk("disch_n", 3'(off_n), 3'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
